// File: logic/usrt_core.sv
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
// Contract
// - Empty flag high exactly when buffer empty
// - Empty irq requested while flag set
// - Data write loads buffer, clears empty
// - Complete flag sets when shifter, buffer empty
// - Complete clears on ack or write-one
// - Complete irq raised when flag sets
// - Parity inserted after data when enabled
// - Transmitter disable waits for drained path
// - Receiver enable takes the input pin
// - Synchronous mode samples on external clock
// - Reception starts on valid start bit
// - Second stop bit ignored by receiver
// - First stop bit moves frame to buffer
// - Unused high data bits read zero
// - Ninth bit, errors stored per frame
// - Receive flag set while buffer nonempty
// - Receiver disable flushes receive buffer
// - Receive irq requested while flag set
// - Start, 5-9 data LSB first, parity, stops
// - Parity is XOR, inverted for odd
// - Shifter reloads right after last stop
// - Two-deep buffer, overrun on fourth start
module usrt_core
    import usrt_pkg::*;
#(
    parameter int OVERSAMPLE = 16  // Internal ticks per bit in asynchronous mode
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Serial pins
    input wire logic i_serial_in_pin,
    input wire logic i_sync_clock_pin,
    output logic o_serial_out_pin,
    output logic o_serial_out_oe,
    output logic o_serial_in_owned,
    // Interrupt requests and acknowledge from the interrupt controller
    input wire logic i_tx_complete_ack,
    output logic o_rx_complete_irq,
    output logic o_tx_empty_irq,
    output logic o_tx_complete_irq
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rxd_sync_reg;  // Two stages for the serial input
    logic [1:0] xck_sync_reg;  // Two stages for the external clock
    logic xck_prev_reg;        // Previous synchronised clock level
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            rxd_sync_reg <= 2'h3;
            xck_sync_reg <= 2'h0;
            xck_prev_reg <= 1'b0;
        end else begin
            rxd_sync_reg <= {rxd_sync_reg[0], i_serial_in_pin};
            xck_sync_reg <= {xck_sync_reg[0], i_sync_clock_pin};
            xck_prev_reg <= xck_sync_reg[1];
        end
    end
    logic rxd;       // Synchronised serial input
    logic xck_rise;  // External clock rising edge
    logic xck_fall;  // External clock falling edge
    assign rxd = rxd_sync_reg[1];
    assign xck_rise = xck_sync_reg[1] & ~xck_prev_reg;
    assign xck_fall = ~xck_sync_reg[1] & xck_prev_reg;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    logic [7:0] csb_reg;  // Enables, size bit 2, ninth bits
    logic [7:0] csc_reg;  // Mode, parity, stop bits, size bits
    logic [15:0] div_reg; // Tick divider for asynchronous mode
    logic bus_wr;         // Accepted write this cycle
    logic bus_rd;         // Accepted read this cycle
    logic [2:0] sz;       // Character size code
    logic [3:0] nbits;    // Data bits per character
    assign sz = {csb_reg[CSB_SZ2], csc_reg[CSC_SZ_HI:CSC_SZ_LO]};
    // Codes 0..3 give 5..8 bits, code 7 gives 9
    assign nbits = (sz == 3'h7) ? 4'h9 : (4'h5 + {2'h0, sz[1:0]});
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            csb_reg <= CSB_RESET;
            csc_reg <= CSC_RESET;
            div_reg <= DIV_RESET;
        end else if (bus_wr) begin
            if (i_address == ADDR_CSB) begin
                // Receive ninth bit is read-only
                csb_reg <= {i_writedata[7:2], 1'b0, i_writedata[0]};
            end else if (i_address == ADDR_CSC) begin
                csc_reg <= i_writedata[7:0];
                div_reg <= i_writedata[CSC_DIV_LSB +: 16];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bit-rate tick: one enable pulse per oversample period
    // ----------------------------------------------------------------
    logic [15:0] div_cnt_reg;  // Divider counter
    logic tick;                // Oversample enable
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || div_cnt_reg == div_reg) begin
            div_cnt_reg <= 16'h0000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end
    assign tick = (div_cnt_reg == div_reg);

    // ----------------------------------------------------------------
    // Transmit buffer
    // ----------------------------------------------------------------
    logic [8:0] txbuf_reg;  // Pending character with ninth bit
    logic txbuf_full_reg;   // Buffer holds unsent data
    logic tx_load;          // Shifter takes the buffer
    logic data_wr;          // Write to the data register
    assign data_wr = bus_wr && (i_address == ADDR_DATA);
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            txbuf_reg <= 9'h000;
            txbuf_full_reg <= 1'b0;
        end else if (data_wr) begin
            // Ninth bit latched with the low byte
            txbuf_reg <= {csb_reg[CSB_TX_NINTH_BIT], i_writedata[7:0]};
            txbuf_full_reg <= 1'b1;
        end else if (tx_load) begin
            txbuf_full_reg <= 1'b0;  // Moved into the shifter
        end
    end

    // ----------------------------------------------------------------
    // Transmit shifter
    // ----------------------------------------------------------------
    usrt_tx_state_t tx_state_reg;  // Transmit sequencer
    logic [8:0] tx_sh_reg;         // Data being shifted
    logic [3:0] tx_cnt_reg;        // Bits left in data phase
    logic [4:0] tx_os_reg;         // Oversample counter
    logic tx_par_reg;              // Running parity
    logic tx_en_eff_reg;           // Transmitter owns the pin
    logic tx_bit_end;              // End of current bit time
    logic tx_done;                 // Last stop bit finished
    // Synchronous mode shifts on the external falling edge
    assign tx_bit_end = csc_reg[CSC_SYNC] ? xck_fall :
        (tick && tx_os_reg == 5'(OVERSAMPLE - 1));
    assign tx_done = tx_bit_end && ((tx_state_reg == TX_STOP2) ||
        (tx_state_reg == TX_STOP1 && !csc_reg[CSC_STOP2]));
    // Load when idle (sync: on clock fall, so start is whole) or after last stop
    assign tx_load = tx_en_eff_reg && txbuf_full_reg &&
        ((tx_state_reg == TX_IDLE && (!csc_reg[CSC_SYNC] || xck_fall)) || tx_done);
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || tx_state_reg == TX_IDLE || tx_load) begin
            tx_os_reg <= 5'h00;
        end else if (tick && !csc_reg[CSC_SYNC]) begin
            tx_os_reg <= tx_bit_end ? 5'h00 : tx_os_reg + 5'h01;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tx_state_reg <= TX_IDLE;
            tx_sh_reg <= 9'h000;
            tx_cnt_reg <= 4'h0;
            tx_par_reg <= 1'b0;
        end else if (tx_load) begin
            tx_state_reg <= TX_START;
            tx_sh_reg <= txbuf_reg;
            tx_cnt_reg <= nbits;
            tx_par_reg <= csc_reg[CSC_PM0];  // Odd parity starts inverted
        end else if (tx_bit_end) begin
            case (tx_state_reg)
                TX_START: tx_state_reg <= TX_DATA;
                TX_DATA: begin
                    // LSB first, parity accumulates each bit
                    tx_par_reg <= tx_par_reg ^ tx_sh_reg[0];
                    tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
                    tx_cnt_reg <= tx_cnt_reg - 4'h1;
                    if (tx_cnt_reg == 4'h1) begin
                        // Parity slot only when enabled
                        tx_state_reg <= csc_reg[CSC_PM1] ? TX_PAR : TX_STOP1;
                    end
                end
                TX_PAR: tx_state_reg <= TX_STOP1;
                TX_STOP1: tx_state_reg <= csc_reg[CSC_STOP2] ? TX_STOP2 : TX_IDLE;
                TX_STOP2: tx_state_reg <= TX_IDLE;
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end
    // Disable waits for shifter and buffer to drain
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            tx_en_eff_reg <= 1'b0;
        end else if (csb_reg[CSB_TRANSMITTER_ENABLE]) begin
            tx_en_eff_reg <= 1'b1;
        end else if (tx_state_reg == TX_IDLE && !txbuf_full_reg) begin
            tx_en_eff_reg <= 1'b0;
        end
    end
    // Line level and pin ownership
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_serial_out_pin <= 1'b1;
            o_serial_out_oe <= 1'b0;
        end else begin
            o_serial_out_oe <= tx_en_eff_reg;
            case (tx_state_reg)
                TX_START: o_serial_out_pin <= 1'b0;
                TX_DATA: o_serial_out_pin <= tx_sh_reg[0];
                TX_PAR: o_serial_out_pin <= tx_par_reg;
                default: o_serial_out_pin <= 1'b1;  // Idle and stops high
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Transmit complete flag
    // ----------------------------------------------------------------
    logic txc_reg;  // Transmit complete
    logic txc_clr;  // Write-one clear or interrupt acknowledge
    assign txc_clr = i_tx_complete_ack ||
        (bus_wr && i_address == ADDR_CSA && i_writedata[CSA_TXC]);
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            txc_reg <= 1'b0;
        end else if (tx_done && !tx_load) begin
            txc_reg <= 1'b1;  // Set wins over a clear
        end else if (txc_clr) begin
            txc_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    logic rx_en;                   // Receiver enabled, owns the pin
    usrt_rx_state_t rx_state_reg;  // Receive sequencer
    logic [4:0] rx_os_reg;         // Oversample counter
    logic [8:0] rx_sh_reg;         // Receive shift register
    logic [3:0] rx_cnt_reg;        // Data bits left
    logic rx_par_reg;              // Running parity check
    logic rx_pe_reg;               // Parity error of frame in shifter
    logic rx_wait_reg;             // Finished frame held for a full buffer
    usrt_rx_word_t rx_word_reg;    // Frame waiting in the shifter
    logic rx_sample;               // Bit sampling point
    logic rx_push;                 // Frame enters the buffer
    logic rx_overrun;              // New start with buffer and shifter full
    logic [1:0] rx_count_reg;      // Frames in buffer
    assign rx_en = csb_reg[CSB_RXEN];
    // Sync mode samples on external rising edge
    assign rx_sample = csc_reg[CSC_SYNC] ? xck_rise :
        (tick && rx_os_reg == 5'((rx_state_reg == RX_START) ?
        (OVERSAMPLE / 2 - 1) : (OVERSAMPLE - 1)));
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || rx_state_reg == RX_IDLE || rx_sample) begin
            rx_os_reg <= 5'h00;
        end else if (tick) begin
            rx_os_reg <= rx_os_reg + 5'h01;
        end
    end
    assign rx_overrun = rx_state_reg == RX_IDLE && !rxd && rx_wait_reg;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !rx_en) begin
            // Disabling stops reception at once
            rx_state_reg <= RX_IDLE;
            rx_sh_reg <= 9'h000;
            rx_cnt_reg <= 4'h0;
            rx_par_reg <= 1'b0;
            rx_pe_reg <= 1'b0;
        end else begin
            case (rx_state_reg)
                RX_IDLE: if (!rxd && !rx_overrun) begin
                    rx_state_reg <= RX_START;
                end
                RX_START: if (rx_sample) begin
                    // Start bit must still be low when sampled
                    rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
                    rx_cnt_reg <= nbits;
                    rx_sh_reg <= 9'h000;
                    rx_par_reg <= csc_reg[CSC_PM0];
                end
                RX_DATA: if (rx_sample) begin
                    rx_sh_reg <= {rxd, rx_sh_reg[8:1]};
                    rx_par_reg <= rx_par_reg ^ rxd;
                    rx_cnt_reg <= rx_cnt_reg - 4'h1;
                    if (rx_cnt_reg == 4'h1) begin
                        rx_state_reg <= csc_reg[CSC_PM1] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (rx_sample) begin
                    rx_pe_reg <= rx_par_reg ^ rxd;
                    rx_state_reg <= RX_STOP;
                end
                RX_STOP: if (rx_sample) begin
                    // Only first stop bit used; a second one reads as idle
                    rx_state_reg <= RX_IDLE;
                    rx_pe_reg <= 1'b0;
                end
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end
    // Finished frame, right-aligned so unused high bits are zero
    logic [8:0] rx_aligned;
    assign rx_aligned = rx_sh_reg >> (4'h9 - nbits);
    logic rx_frame_end;  // First stop bit sampled
    assign rx_frame_end = rx_en && rx_state_reg == RX_STOP && rx_sample;
    logic dor_pend_reg;  // Overrun seen, tag next stored frame
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !rx_en) begin
            rx_wait_reg <= 1'b0;
            rx_word_reg <= '0;
            dor_pend_reg <= 1'b0;
        end else begin
            if (rx_overrun) begin
                dor_pend_reg <= 1'b1;
            end else if (rx_push) begin
                dor_pend_reg <= 1'b0;  // Cleared on a successful move
            end
            if (rx_frame_end) begin
                rx_word_reg <= '{fe: ~rxd, dor: 1'b0,
                    pe: rx_pe_reg & csc_reg[CSC_PM1], data: rx_aligned};
                rx_wait_reg <= 1'b1;
            end else if (rx_push) begin
                rx_wait_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive buffer (two frames with status)
    // ----------------------------------------------------------------
    usrt_rx_word_t rx_mem [RX_DEPTH];  // Buffer storage
    logic rx_rd_ptr_reg;               // Oldest frame
    logic rx_wr_ptr_reg;               // Next free slot
    logic rx_pop;                      // Data register read
    assign rx_pop = bus_rd && i_address == ADDR_DATA && rx_count_reg != 2'h0;
    assign rx_push = rx_wait_reg && (rx_count_reg != 2'(RX_DEPTH) || rx_pop);
    always_ff @(posedge i_mclk) begin
        if (rx_push) begin
            rx_mem[rx_wr_ptr_reg] <= '{fe: rx_word_reg.fe,
                dor: dor_pend_reg | rx_overrun, pe: rx_word_reg.pe,
                data: rx_word_reg.data};
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || !rx_en) begin
            // Flush on disable
            rx_rd_ptr_reg <= 1'b0;
            rx_wr_ptr_reg <= 1'b0;
            rx_count_reg <= 2'h0;
        end else begin
            if (rx_push) begin
                rx_wr_ptr_reg <= ~rx_wr_ptr_reg;
            end
            if (rx_pop) begin
                rx_rd_ptr_reg <= ~rx_rd_ptr_reg;  // Read advances the buffer
            end
            rx_count_reg <= rx_count_reg + {1'b0, rx_push} - {1'b0, rx_pop};
        end
    end
    usrt_rx_word_t rx_head;  // Frame visible to software
    logic rxc;               // Unread data present
    assign rxc = rx_count_reg != 2'h0;
    assign rx_head = rxc ? rx_mem[rx_rd_ptr_reg] : '0;

    // ----------------------------------------------------------------
    // Avalon-MM slave: one wait state, then answer
    // ----------------------------------------------------------------
    logic wait_done_reg;  // Request has waited its cycle
    assign bus_wr = i_write && wait_done_reg;
    assign bus_rd = i_read && wait_done_reg;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || wait_done_reg) begin
            wait_done_reg <= 1'b0;
            o_waitrequest <= 1'b1;
        end else begin
            wait_done_reg <= i_read || i_write;
            o_waitrequest <= !(i_read || i_write);
        end
    end
    logic [31:0] rd_next;  // Read mux
    always_comb begin
        rd_next = 32'h0000_0000;
        // Ninth bit and status come from the head frame
        if (i_address == ADDR_DATA) begin
            rd_next[7:0] = rx_head.data[7:0];
        end else if (i_address == ADDR_CSA) begin
            rd_next[CSA_RXC] = rxc;
            rd_next[CSA_TXC] = txc_reg;
            rd_next[CSA_UDRE] = ~txbuf_full_reg;
            rd_next[CSA_FE] = rx_head.fe;
            rd_next[CSA_DOR] = rx_head.dor;
            rd_next[CSA_PE] = rx_head.pe;
        end else if (i_address == ADDR_CSB) begin
            rd_next[7:0] = {csb_reg[7:2], rx_head.data[8], csb_reg[CSB_TX_NINTH_BIT]};
        end else if (i_address == ADDR_CSC) begin
            rd_next = {div_reg, 8'h00, csc_reg};
        end
    end
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_readdata <= 32'h0000_0000;
        end else if (i_read && !wait_done_reg) begin
            o_readdata <= rd_next;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt requests and pin ownership
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            o_tx_empty_irq <= 1'b0;
            o_tx_complete_irq <= 1'b0;
            o_rx_complete_irq <= 1'b0;
            o_serial_in_owned <= 1'b0;
        end else begin
            o_tx_empty_irq <= csb_reg[CSB_UDRIE] & ~txbuf_full_reg;
            o_tx_complete_irq <= csb_reg[CSB_TXCIE] & txc_reg & ~txc_clr;
            o_rx_complete_irq <= csb_reg[CSB_RXCIE] & rxc & ~rx_pop;
            o_serial_in_owned <= rx_en;
        end
    end
endmodule : usrt_core

// File: common/usrt_pkg.sv
package usrt_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses, one 32-bit word each)
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_DATA = 4'h0;   // Data register
    localparam logic [3:0] ADDR_CSA = 4'h4;    // Control/status A
    localparam logic [3:0] ADDR_CSB = 4'h8;    // Control/status B
    localparam logic [3:0] ADDR_CSC = 4'hc;    // Frame format / baud
    // Control/status A fields
    localparam int CSA_RXC = 7;
    localparam int CSA_TXC = 6;
    localparam int CSA_UDRE = 5;
    localparam int CSA_FE = 4;
    localparam int CSA_DOR = 3;
    localparam int CSA_PE = 2;
    // Control/status B fields
    localparam int CSB_RXCIE = 7;
    localparam int CSB_TXCIE = 6;
    localparam int CSB_UDRIE = 5;
    localparam int CSB_RXEN = 4;
    localparam int CSB_TRANSMITTER_ENABLE = 3;
    localparam int CSB_SZ2 = 2;
    localparam int CSB_RXB8 = 1;
    localparam int CSB_TX_NINTH_BIT = 0;
    // Control/status C fields
    localparam int CSC_SYNC = 6;
    localparam int CSC_PM1 = 5;
    localparam int CSC_PM0 = 4;
    localparam int CSC_STOP2 = 3;
    localparam int CSC_SZ_HI = 2;
    localparam int CSC_SZ_LO = 1;
    localparam int CSC_DIV_LSB = 16;
    // Reset values
    localparam logic [7:0] CSB_RESET = 8'h00;
    localparam logic [7:0] CSC_RESET = 8'h06;
    localparam logic [15:0] DIV_RESET = 16'h0000;
    // Receive buffer depth and access latency
    localparam int RX_DEPTH = 2;
    localparam int BUS_WAIT = 1;

    // Received frame as stored in the receive buffer
    typedef struct packed {
        logic fe;
        logic dor;
        logic pe;
        logic [8:0] data;
    } usrt_rx_word_t;

    // Transmitter sequencer
    typedef enum logic [5:0] {
        TX_IDLE = 6'b000001,
        TX_START = 6'b000010,
        TX_DATA = 6'b000100,
        TX_PAR = 6'b001000,
        TX_STOP1 = 6'b010000,
        TX_STOP2 = 6'b100000
    } usrt_tx_state_t;

    // Receiver sequencer
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_START = 5'b00010,
        RX_DATA = 5'b00100,
        RX_PAR = 5'b01000,
        RX_STOP = 5'b10000
    } usrt_rx_state_t;
endpackage : usrt_pkg

// File: tb/usrt_checker.sv
`timescale 1ns/100ps
// ----
// Port checker
// ----
module usrt_checker (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic o_waitrequest,
    input wire logic i_serial_in_pin,
    input wire logic o_serial_out_pin,
    input wire logic o_serial_out_oe,
    input wire logic o_serial_in_owned,
    input wire logic i_tx_complete_ack,
    input wire logic o_rx_complete_irq,
    input wire logic o_tx_complete_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    AST_BUS_ANSWER: assert property ($rose(i_read | i_write) |=> !o_waitrequest)
        else $error("bus answer late");
    // Each line level lasts at least half a bit
    AST_BIT_HOLD: assert property
        ($changed(o_serial_out_pin) && o_serial_out_oe |=> $stable(o_serial_out_pin) [*8])
        else $error("line level too short");
    AST_TXC_IDLE: assert property ($rose(o_tx_complete_irq) |-> o_serial_out_pin)
        else $error("complete before stop");
    AST_TXC_ACK: assert property (i_tx_complete_ack |-> ##[1:3] !o_tx_complete_irq)
        else $error("ack did not clear");
    // Release only after a stop bit, never mid-frame
    AST_TX_RELEASE: assert property
        ($fell(o_serial_out_oe) |-> o_serial_out_pin && $past(o_serial_out_pin, 8))
        else $error("pin released early");
    AST_RX_OWNED: assert property ($rose(o_rx_complete_irq) |-> o_serial_in_owned)
        else $error("rx while disabled");
    AST_RX_FLUSH: assert property
        ($fell(o_serial_in_owned) |-> ##[0:3] !o_rx_complete_irq) else $error("no flush");
    AST_RX_STOP: assert property ($rose(o_rx_complete_irq) |-> $past(i_serial_in_pin, 3))
        else $error("frame stored off stop");
    cover property ($rose(o_tx_complete_irq));
    cover property ($rose(o_rx_complete_irq));
    cover property ($fell(o_serial_out_oe));
endmodule : usrt_checker

// File: tb/usrt_partner.sv
`timescale 1ns/100ps
// ----
// Remote node: echoes every frame and checks it
// ----
module usrt_partner (
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_oe,
    output logic o_rxd,
    output logic o_bad
);
    logic [7:0] dly_reg = 8'hff; // Half a bit of delay, so checks land mid-bit
    logic [10:0] frm;
    // Released line reads high, as through a pull-up
    always @(posedge i_clk) dly_reg <= {dly_reg[6:0], i_oe === 1'b1 ? i_txd : 1'b1};
    assign o_rxd = dly_reg[7];
    // Start low, even parity, stop high; 16 clocks per bit
    initial begin
        o_bad = 1'b0;
        forever begin
            @(negedge o_rxd);
            for (int n = 0; n < 11; n++) begin
                repeat (n == 0 ? 1 : 16) @(posedge i_clk);
                frm[n] = i_txd;
            end
            if (frm[0] || !frm[10] || ^frm[9:1]) o_bad = 1'b1;
        end
    end
endmodule : usrt_partner

// File: tb/tb.sv
`timescale 1ns/100ps
// ----
// Bench: register traffic in, echoed frames back
// ----
module tb
    import usrt_pkg::*;
;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_read = 1'b0, i_write = 1'b0;
    logic i_tx_complete_ack = 1'b0, i_sync_clock_pin = 1'b0;
    logic [3:0] i_address = 4'h0;
    logic [31:0] i_writedata = 32'h0, o_readdata, m;
    logic o_waitrequest, o_serial_out_pin, o_serial_out_oe, o_serial_in_owned;
    logic o_rx_complete_irq, o_tx_empty_irq, o_tx_complete_irq, i_serial_in_pin, bad;
    logic [31:0] exp_q[$], msk_q[$];
    logic [7:0] sent_q[$], b;
    int num_errors = 0, checks = 0;
    usrt_core #(.OVERSAMPLE(16)) dut (.*);
    usrt_partner far (.i_clk(i_mclk), .i_txd(o_serial_out_pin), .i_oe(o_serial_out_oe),
        .o_rxd(i_serial_in_pin), .o_bad(bad));
    initial forever #2 i_mclk = ~i_mclk;
    // External link clock, free running; only the synchronous scenario uses it
    initial forever #32 i_sync_clock_pin = ~i_sync_clock_pin;
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (e !== g) begin
            num_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    // Holds the request until waitrequest is sampled low; reads note the expectation
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [31:0] msk);
        @(posedge i_mclk);
        i_address <= a;
        i_writedata <= d;
        i_read <= !wr;
        i_write <= wr;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(msk);
        end
        @(posedge i_mclk);
        while (o_waitrequest) @(posedge i_mclk);
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus
    // Starts one edge late so a flag lowered by the last access is not seen as still high
    task automatic wt(input logic rx);
        @(posedge i_mclk);
        for (int n = 0; n < 3000 && (rx ? !o_rx_complete_irq : !o_tx_complete_irq); n++)
            @(posedge i_mclk);
        if (rx ? !o_rx_complete_irq : !o_tx_complete_irq)
            num_errors++;  // Waited too long
    endtask : wt
    task automatic print_verdict();
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    // Read results are compared against the oldest note
    always @(posedge i_mclk) if (i_read && !o_waitrequest) begin
        m = msk_q.pop_front();
        chk(exp_q.pop_front() & m, o_readdata & m);
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        num_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(86));
        repeat (10) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        bus(1, ADDR_CSC, 32'h26, 0);
        bus(1, ADDR_CSB, 32'hf8, 0);
        repeat (3) @(posedge i_mclk);
        chk(1, o_tx_empty_irq);
        // Two writes back to back: second waits in the buffer
        for (int k = 0; k < 2; k++) begin
            b = 8'($urandom);
            sent_q.push_back(b);
            bus(1, ADDR_DATA, {24'h0, b}, 0);
        end
        bus(0, ADDR_CSA, 0, 32'h20);
        for (int k = 0; k < 2; k++) begin
            wt(1);
            bus(0, ADDR_CSA, 32'h80, 32'h9c);
            bus(0, ADDR_CSB, 32'hf8, '1);
            bus(0, ADDR_DATA, {24'h0, sent_q.pop_front()}, '1);
        end
        bus(0, ADDR_CSA, 0, 32'h80);
        wt(0);
        bus(0, ADDR_CSA, 32'h60, 32'h60);
        i_tx_complete_ack <= 1'b1;
        @(posedge i_mclk);
        i_tx_complete_ack <= 1'b0;
        bus(0, ADDR_CSA, 0, 32'h40);
        bus(1, ADDR_DATA, 32'h5a, 0);
        wt(1);
        wt(0);
        bus(1, ADDR_CSB, 32'hc8, 0);
        bus(1, ADDR_CSA, 32'h40, 0);
        bus(0, ADDR_CSA, 0, 32'hc0);
        chk(0, o_tx_empty_irq);
        chk(0, o_serial_in_owned);
        bus(0, 4'h1, 0, '1);
        // Synchronous mode, two stop bits: line clocked by the external pin
        bus(1, ADDR_CSC, 32'h6e, 0);
        bus(1, ADDR_CSB, 32'h98, 0);
        bus(1, ADDR_DATA, 32'ha5, 0);
        wt(1);
        chk(1, o_serial_in_owned);
        bus(0, ADDR_CSA, 32'h80, 32'h9c);
        bus(0, ADDR_DATA, 32'ha5, '1);
        // Disable with a frame still going out
        bus(1, ADDR_DATA, {24'h0, b}, 0);
        bus(1, ADDR_CSB, 0, 0);
        chk(1, o_serial_out_oe);
        repeat (300) @(posedge i_mclk);
        chk(0, o_serial_out_oe);
        chk(0, bad);
        print_verdict();
    end
endmodule : tb
bind usrt_core usrt_checker chk_i (.*);
